// [hdl/afsr_pkg.sv]
// Package of constants for the frame-synchronised converter readout block
package afsr_pkg;
   // ==========================================================
   // Frame layout
   localparam int AFSR_WORD_BITS = 24;
   localparam int AFSR_NUM_CH = 2;
   localparam int AFSR_FRAME_WORDS = AFSR_NUM_CH + 2;
   // ==========================================================
   // Status word fields
   localparam int AFSR_STAT_RESYNC_BIT = 13;
   localparam int AFSR_STAT_FRESH_BIT = 0;
   localparam logic [15:0] AFSR_STAT_RESET = 16'h0500;
   // ==========================================================
   // Conversion timing, in master clock cycles
   localparam int AFSR_CONV_PERIOD = 32;
   localparam int AFSR_SYNC_TOL = 1;
   localparam logic [AFSR_WORD_BITS-1:0] AFSR_ZERO_WORD = 24'h000000;
   // ==========================================================
   // Serial phase states
   typedef enum logic [1:0] {AFSR_IDLE, AFSR_SHIFT, AFSR_DONE} afsr_phase_t;
endpackage

// [hdl/afsr_edge_sync.sv]
// Two-stage synchroniser with rise and fall detection
module afsr_edge_sync
   import afsr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic async_in,
   input wire logic init_level,
   output logic level_q,
   output logic rise,
   output logic fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         // Idle level at reset, so no false edge follows release
         meta_q <= init_level;
         sync_q <= init_level;
         prev_q <= init_level;
      end
      else if (clk_en)
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // First stage feeds only the second
   assign level_q = sync_q;
   assign rise = clk_en & sync_q & ~prev_q;
   assign fall = clk_en & ~sync_q & prev_q;
endmodule

// [hdl/afsr_readout.sv]
// Converter readout core: sync check, frame acknowledge and serial output
// ==========================================================
module afsr_readout
   import afsr_pkg::*;
#(
   parameter int WORD_BITS = AFSR_WORD_BITS,
   parameter int NUM_CH = AFSR_NUM_CH,
   parameter int CONV_PERIOD = AFSR_CONV_PERIOD
)
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic master_clock_input,
   input wire logic sync_reset_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [WORD_BITS*NUM_CH-1:0] sample_data,
   input wire logic status_clear,
   output logic dout_o,
   output logic dout_oe_n,
   output logic conversion_ready_out,
   output logic resync_fault_flag
);
   localparam int FRAME_WORDS = NUM_CH + 2;
   localparam int FRAME_BITS = FRAME_WORDS * WORD_BITS;
   localparam int BW = $clog2(FRAME_BITS + 1);
   localparam int CW = $clog2(CONV_PERIOD);

   // Status word needs 16 bits; a grid shorter than 4 cannot tell on from off
   if (WORD_BITS < 16 || NUM_CH < 1 || CONV_PERIOD < 4)
   begin : g_bad_params
      $error("afsr_readout: unsupported parameters");
   end

   // ==========================================================
   // Pin synchronisers
   logic mclk_rise;
   logic sync_rise;
   logic cs_lvl, cs_rise, cs_fall;
   logic sclk_rise, sclk_fall;

   // Init levels match each pin's idle level
   afsr_edge_sync u_mclk (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .async_in(master_clock_input),
      .init_level(1'b0), .level_q(), .rise(mclk_rise), .fall());
   afsr_edge_sync u_sync (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .async_in(sync_reset_n),
      .init_level(1'b1), .level_q(), .rise(sync_rise), .fall());
   afsr_edge_sync u_cs (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .async_in(cs_n),
      .init_level(1'b1), .level_q(cs_lvl), .rise(cs_rise), .fall(cs_fall));
   afsr_edge_sync u_sclk (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .async_in(sclk),
      .init_level(1'b0), .level_q(), .rise(sclk_rise), .fall(sclk_fall));

   // ==========================================================
   // Conversion grid on the master clock
   logic [CW-1:0] phase_q;
   logic conv_tick;
   logic sync_on_grid;
   logic sync_strobe;
   assign conv_tick = mclk_rise && (phase_q == CW'(CONV_PERIOD - 1));
   // Sync strobe ends on rising edge; aligned only at grid boundary
   assign sync_strobe = sync_rise;
   assign sync_on_grid = (phase_q == '0) || (phase_q == CW'(CONV_PERIOD - 1));

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         phase_q <= '0;
      else if (clk_en && mclk_rise)
         phase_q <= conv_tick ? '0 : phase_q + CW'(1); // Sync never restarts the grid
   end

   // ==========================================================
   // Resync fault flag: set beats clear
   logic fault_q;
   logic fault_set;
   assign fault_set = sync_strobe && !sync_on_grid;
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         fault_q <= 1'b0;
      else if (clk_en)
      begin
         if (fault_set)
            fault_q <= 1'b1;
         else if (status_clear)
            fault_q <= 1'b0;
      end
   end
   assign resync_fault_flag = fault_q;

   // ==========================================================
   // Result latch and read acknowledge
   logic [WORD_BITS*NUM_CH-1:0] held_q;
   logic fresh_q;
   logic ready_q;
   logic [BW-1:0] bit_cnt_q;
   logic frame_full;
   logic frame_done;
   logic shifting;
   assign shifting = !cs_lvl;
   assign frame_full = (bit_cnt_q == BW'(FRAME_BITS));
   assign frame_done = cs_rise && frame_full; // Partial frame leaves data unread

   // A tick during a frame is dropped; keeps the shifted words consistent
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         held_q <= '0;
         fresh_q <= 1'b0;
         ready_q <= 1'b1;
      end
      else if (clk_en)
      begin
         if (conv_tick && !shifting)
         begin
            held_q <= sample_data;
            fresh_q <= 1'b1;
            ready_q <= 1'b0;
         end
         else if (frame_done)
         begin
            fresh_q <= 1'b0;
            ready_q <= 1'b1;
         end
      end
   end
   assign conversion_ready_out = ready_q; // Shared pacing across devices

   // ==========================================================
   // Frame shift register: status, channels, trailing word
   logic [FRAME_BITS-1:0] frame_q;
   logic [FRAME_BITS-1:0] frame_load;
   logic [15:0] status_word;
   logic dout_q;
   logic oe_n_q;
   assign status_word = AFSR_STAT_RESET | (16'(fault_q) << AFSR_STAT_RESYNC_BIT)
      | (16'(fresh_q) << AFSR_STAT_FRESH_BIT);
   assign frame_load = {status_word, {(WORD_BITS-16){1'b0}}, held_q, {WORD_BITS{1'b0}}};

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         frame_q <= '0;
         bit_cnt_q <= '0;
         dout_q <= 1'b0;
         oe_n_q <= 1'b1;
      end
      else if (clk_en)
      begin
         oe_n_q <= cs_lvl; // Released while chip select high
         if (cs_fall)
         begin
            frame_q <= frame_load;
            bit_cnt_q <= '0;
            dout_q <= frame_load[FRAME_BITS-1];
         end
         else if (shifting && sclk_fall && !frame_full)
         begin
            frame_q <= {frame_q[FRAME_BITS-2:0], 1'b0};
            dout_q <= frame_q[FRAME_BITS-2];
         end
         if (shifting && sclk_rise && !frame_full)
            bit_cnt_q <= bit_cnt_q + BW'(1);
      end
   end
   assign dout_o = dout_q;
   assign dout_oe_n = oe_n_q;

   // ==========================================================
   // Checks
   sequence s_partial_frame;
      cs_rise && !frame_full;
   endsequence

   sequence s_ready_low_idle;
      clk_en && !conversion_ready_out && !frame_done;
   endsequence

   a_fault_sets: assert property (@(posedge clk_sys) disable iff (srst)
      clk_en && fault_set |=> resync_fault_flag)
      else $error("resync fault not set");
   a_sync_no_restart: assert property (@(posedge clk_sys) disable iff (srst)
      clk_en && sync_rise && !mclk_rise |=> phase_q == $past(phase_q))
      else $error("sync pin moved the conversion grid");
   a_partial_keeps: assert property (@(posedge clk_sys) disable iff (srst)
      (s_partial_frame and (clk_en && !conv_tick)) |=> fresh_q == $past(fresh_q))
      else $error("partial frame acknowledged data");
   a_full_acks: assert property (@(posedge clk_sys) disable iff (srst)
      clk_en && frame_done && !conv_tick |=> !fresh_q && conversion_ready_out)
      else $error("full frame not acknowledged");
   a_hiz_cs_high: assert property (@(posedge clk_sys) disable iff (srst)
      clk_en && cs_lvl |=> dout_oe_n)
      else $error("output driven while chip select high");
   a_drive_cs_low: assert property (@(posedge clk_sys) disable iff (srst)
      clk_en && !cs_lvl |=> !dout_oe_n)
      else $error("output not driven during frame");
   a_ready_on_conv: assert property (@(posedge clk_sys) disable iff (srst)
      clk_en && conv_tick && !shifting |=> !conversion_ready_out && fresh_q)
      else $error("ready not asserted at conversion");
   a_first_bit: assert property (@(posedge clk_sys) disable iff (srst)
      clk_en && cs_fall |=> !dout_oe_n && dout_o == $past(status_word[15]))
      else $error("first output bit wrong");
   a_ready_holds: assert property (@(posedge clk_sys) disable iff (srst)
      s_ready_low_idle |=> !conversion_ready_out)
      else $error("ready rose without a full frame");
   a_fault_sticky: assert property (@(posedge clk_sys) disable iff (srst)
      clk_en && resync_fault_flag && !status_clear |=> resync_fault_flag)
      else $error("resync fault dropped without a clear");
endmodule

// [testbench/afsr_host_model.sv]
// Host model: master clock, sync strobes and serial frame reads
module afsr_host_model
   import afsr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic dout_o,
   input wire logic dout_oe_n,
   output logic master_clock_input,
   output logic sync_reset_n,
   output logic cs_n,
   output logic sclk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [95:0] frame_q;
   int mc_cnt;
   event frame_ev;
   // ==========================================================
   // Master clock, 80 ns, owned by the host so its periods are known
   initial
   begin
      master_clock_input = 1'b0;
      sync_reset_n = 1'b1;
      cs_n = 1'b1;
      sclk = 1'b0;
      mc_cnt = 0;
   end
   always @(negedge clk_sys)
   begin
      mc_cnt <= (mc_cnt == 4) ? 0 : mc_cnt + 1;
      if (mc_cnt == 4)
         master_clock_input <= ~master_clock_input;
   end
   // ==========================================================
   // Serial reads; a released line reads unknown so it can never match
   task automatic read_frame(input int nbits);
      logic [95:0] f;
      f = '0;
      cs_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      for (int i = 0; i < nbits; i++)
      begin
         f = {f[94:0], (dout_oe_n === 1'b0) ? dout_o : 1'bx};
         sclk = 1'b1;
         repeat (5) @(negedge clk_sys);
         sclk = 1'b0;
         repeat (5) @(negedge clk_sys);
      end
      cs_n = 1'b1; // Released between frames, never tied low
      frame_q = f;
      if (nbits == 96)
         ->frame_ev;
   endtask
   task automatic strobe_sync();
      sync_reset_n = 1'b0;
      @(negedge clk_sys);
      sync_reset_n = 1'b1;
   endtask
endmodule

// [testbench/afsr_readout_tb.sv]
// Self-checking bench for the converter readout block
module afsr_readout_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import afsr_pkg::*;
   logic clk_sys, srst, clk_en, status_clear, dout_o, dout_oe_n;
   logic master_clock_input, sync_reset_n, cs_n, sclk, conversion_ready_out, resync_fault_flag;
   logic [47:0] sample_data;
   logic [72:0] exp_q[$];
   int fail_count = 0;
   int checked = 0;
   afsr_readout dut_u (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
      .master_clock_input(master_clock_input), .sync_reset_n(sync_reset_n), .cs_n(cs_n), .sclk(sclk),
      .sample_data(sample_data), .status_clear(status_clear), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
      .conversion_ready_out(conversion_ready_out), .resync_fault_flag(resync_fault_flag));
   afsr_host_model host_u (.clk_sys(clk_sys), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
      .master_clock_input(master_clock_input), .sync_reset_n(sync_reset_n), .cs_n(cs_n), .sclk(sclk));
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      // A note never matched by a frame counts as a miss
      if (exp_q.size() != 0)
         fail_count++;
      if (fail_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic compare_frame(input logic [72:0] got, input logic [72:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic compare_level(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait for fresh data
   task automatic wait_ready();
      int n;
      n = 0;
      while (conversion_ready_out !== 1'b0)
      begin
         @(negedge clk_sys);
         n++;
         if (n > 2000)
         begin
            fail_count++;
            print_verdict();
         end
      end
   endtask
   // Inputs change mid-frame, where ticks are skipped
   task automatic full_read(input logic fault_exp);
      wait_ready();
      exp_q.push_back({fault_exp, sample_data, 24'h000000});
      fork
         host_u.read_frame(96);
         begin
            repeat (20) @(negedge clk_sys);
            sample_data = 48'({$urandom(), $urandom()});
         end
      join
      repeat (8) @(negedge clk_sys);
      compare_level(conversion_ready_out, 1'b1);
      compare_level(dout_oe_n, 1'b1);
   endtask
   // ==========================================================
   // Frame monitor
   initial
   forever
   begin
      @(host_u.frame_ev);
      if (exp_q.size() == 0)
         fail_count++;
      else
         compare_frame({host_u.frame_q[93], host_u.frame_q[71:0]}, exp_q.pop_front());
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      srst = 1'b1;
      clk_en = 1'b1;
      status_clear = 1'b0;
      void'($urandom(97863));
      sample_data = 48'({$urandom(), $urandom()});
      repeat (12) @(negedge clk_sys);
      srst = 1'b0;
      compare_level(dout_oe_n, 1'b1);
      full_read(1'b0);
      wait_ready();
      host_u.read_frame(40);
      repeat (8) @(negedge clk_sys);
      compare_level(conversion_ready_out, 1'b0);
      full_read(1'b0);
      wait_ready();
      host_u.strobe_sync();
      repeat (8) @(negedge clk_sys);
      compare_level(resync_fault_flag, 1'b0);
      full_read(1'b0);
      for (int i = 0; i < 2; i++)
      begin
         wait_ready();
         repeat (50) @(negedge clk_sys);
         host_u.strobe_sync();
         repeat (8) @(negedge clk_sys);
         compare_level(resync_fault_flag, 1'b1);
         full_read(1'b1);
         status_clear = 1'b1;
         @(negedge clk_sys);
         status_clear = 1'b0;
         repeat (3) @(negedge clk_sys);
         compare_level(resync_fault_flag, 1'b0);
      end
      print_verdict();
   end
endmodule
